// *** hw/som_route_top.sv ***
// Source selector registers for serial output channels 4 to 7, APB slave
// Assumes an APB master on clk and sample streams from logic on clk
//
// Behaviour
// - Channel 5 selector, high nibble, reset 5
// - Channel 4 selector, low nibble, reset 4
// - Channel 7 selector, high nibble, reset 7
// - Channel 6 selector, low nibble, reset 6
// - Codes 4 to 7 pick converter 0-3
// - Codes 8 to 15 pick serial input 0-7
`timescale 1ns/10ps
`default_nettype none

module som_route_top (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [som_pkg::ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [som_pkg::DATA_W-1:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic pready,
    output logic [som_pkg::DATA_W-1:0] prdata,
    output logic pslverr,
    input wire logic [som_pkg::ASRC_CH-1:0][som_pkg::SAMPLE_W-1:0] asrc_sample,
    input wire logic [som_pkg::SIN_CH-1:0][som_pkg::SAMPLE_W-1:0] sin_sample,
    input wire logic sample_valid,
    output wire logic [som_pkg::OUT_CH-1:0][som_pkg::SAMPLE_W-1:0] out_sample,
    output logic out_valid,
    output wire logic [som_pkg::OUT_CH-1:0] out_rsvd
);

    // ************************************************************
    // Bus decode
    // ************************************************************
    logic [som_pkg::REG_W-1:0] route45_q;
    logic [som_pkg::REG_W-1:0] route67_q;
    logic hit45;
    logic hit67;
    logic setup_ph;
    logic acc_wr;
    logic wr45;
    logic wr67;
    logic [som_pkg::DATA_W-1:0] rd_d;

    assign hit45 = (paddr == som_pkg::som_byte_addr(som_pkg::ROUTE45_IDX));
    assign hit67 = (paddr == som_pkg::som_byte_addr(som_pkg::ROUTE67_IDX));
    assign setup_ph = psel && !penable;
    assign acc_wr = psel && penable && pwrite && pstrb[0];
    assign wr45 = acc_wr && hit45;
    assign wr67 = acc_wr && hit67;

    // Zero wait states: read data is captured in the setup cycle
    assign pready = 1'b1;

    // ************************************************************
    // Selector registers
    // ************************************************************
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            route45_q <= som_pkg::ROUTE45_RST;
        end else if (wr45) begin
            route45_q <= pwdata[som_pkg::REG_W-1:0];
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            route67_q <= som_pkg::ROUTE67_RST;
        end else if (wr67) begin
            route67_q <= pwdata[som_pkg::REG_W-1:0];
        end
    end

    // ************************************************************
    // Read path and error answer
    // ************************************************************
    always_comb begin
        rd_d = '0;
        if (hit45) begin
            rd_d[som_pkg::REG_W-1:0] = route45_q;
        end else if (hit67) begin
            rd_d[som_pkg::REG_W-1:0] = route67_q;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            prdata <= '0;
        end else if (setup_ph && !pwrite) begin
            prdata <= rd_d;
        end
    end

    // Unmapped addresses answer with an error and ignore writes
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pslverr <= 1'b0;
        end else if (setup_ph) begin
            pslverr <= !(hit45 || hit67);
        end
    end

    // ************************************************************
    // Channel muxes
    // ************************************************************
    logic [som_pkg::OUT_CH-1:0][som_pkg::SEL_W-1:0] sel;

    assign sel[0] = route45_q[som_pkg::SEL_LO_LSB +: som_pkg::SEL_W];
    assign sel[1] = route45_q[som_pkg::SEL_HI_LSB +: som_pkg::SEL_W];
    assign sel[2] = route67_q[som_pkg::SEL_LO_LSB +: som_pkg::SEL_W];
    assign sel[3] = route67_q[som_pkg::SEL_HI_LSB +: som_pkg::SEL_W];

    for (genvar c = 0; c < som_pkg::OUT_CH; c++) begin : g_ch
        som_chan_mux u_som_chan_mux (
            .clk(clk),
            .rst_n(rst_n),
            .sel(sel[c]),
            .asrc_sample(asrc_sample),
            .sin_sample(sin_sample),
            .sample_valid(sample_valid),
            .out_sample(out_sample[c]),
            .out_rsvd(out_rsvd[c])
        );
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            out_valid <= 1'b0;
        end else begin
            out_valid <= sample_valid;
        end
    end

    // ************************************************************
    // Assertion helpers
    // ************************************************************
    logic h_valid_q;
    logic [som_pkg::OUT_CH-1:0][som_pkg::SEL_W-1:0] h_sel_q;
    logic [som_pkg::ASRC_CH-1:0][som_pkg::SAMPLE_W-1:0] h_asrc_q;
    logic [som_pkg::SIN_CH-1:0][som_pkg::SAMPLE_W-1:0] h_sin_q;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            h_valid_q <= 1'b0;
            h_sel_q <= '0;
            h_asrc_q <= '0;
            h_sin_q <= '0;
        end else begin
            h_valid_q <= sample_valid;
            h_sel_q <= sel;
            h_asrc_q <= asrc_sample;
            h_sin_q <= sin_sample;
        end
    end

    // Reserved flag as the selectors stood at the last edge
    logic [som_pkg::OUT_CH-1:0] h_rsvd;

    always_comb begin
        h_rsvd = '0;
        for (int k = 0; k < som_pkg::OUT_CH; k++) begin
            h_rsvd[k] = (som_pkg::som_src_class(h_sel_q[k]) == som_pkg::SOM_SRC_RSVD);
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    a_reset_ch5: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(rst_n) |-> route45_q[7:4] == som_pkg::ROUTE45_RST[7:4])
        else $error("Channel 5 selector not at reset value");

    a_reset_ch4: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(rst_n) |-> route45_q[3:0] == som_pkg::ROUTE45_RST[3:0])
        else $error("Channel 4 selector not at reset value");

    a_reset_ch7: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(rst_n) |-> route67_q[7:4] == som_pkg::ROUTE67_RST[7:4])
        else $error("Channel 7 selector not at reset value");

    a_reset_ch6: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(rst_n) |-> route67_q[3:0] == som_pkg::ROUTE67_RST[3:0])
        else $error("Channel 6 selector not at reset value");

    a_write_ch45: assert property (@(posedge clk) disable iff (!rst_n)
        wr45 |=> route45_q == $past(pwdata[7:0]))
        else $error("Write to channel 4/5 register lost");

    a_write_ch67: assert property (@(posedge clk) disable iff (!rst_n)
        wr67 |=> route67_q == $past(pwdata[7:0]))
        else $error("Write to channel 6/7 register lost");

    a_hold_ch45: assert property (@(posedge clk) disable iff (!rst_n)
        !wr45 |=> $stable(route45_q))
        else $error("Channel 4/5 register changed without a write");

    a_hold_ch67: assert property (@(posedge clk) disable iff (!rst_n)
        !wr67 |=> $stable(route67_q))
        else $error("Channel 6/7 register changed without a write");

    a_read_back: assert property (@(posedge clk) disable iff (!rst_n)
        (setup_ph && !pwrite && hit67) ##1 (psel && penable)
        |-> prdata == {24'h000000, route67_q})
        else $error("Read data does not match channel 6/7 register");

    a_read_ch45: assert property (@(posedge clk) disable iff (!rst_n)
        (setup_ph && !pwrite && hit45) ##1 (psel && penable)
        |-> prdata == {24'h000000, route45_q})
        else $error("Read data does not match channel 4/5 register");

    a_asrc_route: assert property (@(posedge clk) disable iff (!rst_n)
        (h_valid_q && som_pkg::som_src_class(h_sel_q[0]) == som_pkg::SOM_SRC_ASRC)
        |-> out_sample[0] == h_asrc_q[h_sel_q[0][1:0]])
        else $error("Channel 4 not fed from selected converter");

    a_sin_route: assert property (@(posedge clk) disable iff (!rst_n)
        (h_valid_q && som_pkg::som_src_class(h_sel_q[3]) == som_pkg::SOM_SRC_SIN)
        |-> out_sample[3] == h_sin_q[h_sel_q[3][2:0]])
        else $error("Channel 7 not fed from selected serial input");

    a_valid_delay: assert property (@(posedge clk) disable iff (!rst_n)
        sample_valid ##1 !sample_valid |-> out_valid ##1 !out_valid)
        else $error("Output strobe not one cycle after input strobe");

    a_no_err_mapped: assert property (@(posedge clk) disable iff (!rst_n)
        (setup_ph && (hit45 || hit67)) |=> !pslverr)
        else $error("Mapped register answered with an error");

    a_err_unmapped: assert property (@(posedge clk) disable iff (!rst_n)
        (setup_ph && !(hit45 || hit67)) |=> pslverr)
        else $error("Unmapped address answered without an error");

    a_rd_unmapped: assert property (@(posedge clk) disable iff (!rst_n)
        (setup_ph && !pwrite && !(hit45 || hit67)) |=> prdata == '0)
        else $error("Unmapped read returned nonzero data");

    a_strb_ignored: assert property (@(posedge clk) disable iff (!rst_n)
        (psel && penable && pwrite && !pstrb[0]) |=> $stable(route45_q) && $stable(route67_q))
        else $error("Write without low byte strobe changed a register");

    a_prdata_hold: assert property (@(posedge clk) disable iff (!rst_n)
        !(setup_ph && !pwrite) |=> $stable(prdata))
        else $error("Read data changed outside a read setup cycle");

    a_prdata_upper: assert property (@(posedge clk) disable iff (!rst_n)
        prdata[som_pkg::DATA_W-1:som_pkg::REG_W] == '0)
        else $error("Read data above the register byte not zero");

    a_asrc_ch5: assert property (@(posedge clk) disable iff (!rst_n)
        (h_valid_q && som_pkg::som_src_class(h_sel_q[1]) == som_pkg::SOM_SRC_ASRC)
        |-> out_sample[1] == h_asrc_q[h_sel_q[1][1:0]])
        else $error("Channel 5 not fed from selected converter");

    a_asrc_ch6: assert property (@(posedge clk) disable iff (!rst_n)
        (h_valid_q && som_pkg::som_src_class(h_sel_q[2]) == som_pkg::SOM_SRC_ASRC)
        |-> out_sample[2] == h_asrc_q[h_sel_q[2][1:0]])
        else $error("Channel 6 not fed from selected converter");

    a_asrc_ch7: assert property (@(posedge clk) disable iff (!rst_n)
        (h_valid_q && som_pkg::som_src_class(h_sel_q[3]) == som_pkg::SOM_SRC_ASRC)
        |-> out_sample[3] == h_asrc_q[h_sel_q[3][1:0]])
        else $error("Channel 7 not fed from selected converter");

    a_sin_ch4: assert property (@(posedge clk) disable iff (!rst_n)
        (h_valid_q && som_pkg::som_src_class(h_sel_q[0]) == som_pkg::SOM_SRC_SIN)
        |-> out_sample[0] == h_sin_q[h_sel_q[0][2:0]])
        else $error("Channel 4 not fed from selected serial input");

    a_sin_ch5: assert property (@(posedge clk) disable iff (!rst_n)
        (h_valid_q && som_pkg::som_src_class(h_sel_q[1]) == som_pkg::SOM_SRC_SIN)
        |-> out_sample[1] == h_sin_q[h_sel_q[1][2:0]])
        else $error("Channel 5 not fed from selected serial input");

    a_sin_ch6: assert property (@(posedge clk) disable iff (!rst_n)
        (h_valid_q && som_pkg::som_src_class(h_sel_q[2]) == som_pkg::SOM_SRC_SIN)
        |-> out_sample[2] == h_sin_q[h_sel_q[2][2:0]])
        else $error("Channel 6 not fed from selected serial input");

    a_rsvd_flag: assert property (@(posedge clk) disable iff (!rst_n)
        !$rose(rst_n) |-> out_rsvd == h_rsvd)
        else $error("Reserved code flag does not follow the selectors");

    a_valid_follow: assert property (@(posedge clk) disable iff (!rst_n)
        !$rose(rst_n) |-> out_valid == $past(sample_valid))
        else $error("Output strobe does not follow the input strobe");

    a_sample_hold: assert property (@(posedge clk) disable iff (!rst_n)
        (!h_valid_q && !$rose(rst_n)) |-> $stable(out_sample))
        else $error("Output sample changed without an input strobe");

    // ************************************************************
    // Covers
    // ************************************************************
    c_write45: cover property (@(posedge clk) disable iff (!rst_n) wr45);

    c_read67: cover property (@(posedge clk) disable iff (!rst_n)
        setup_ph && !pwrite && hit67 ##1 psel && penable);

    c_asrc: cover property (@(posedge clk) disable iff (!rst_n)
        h_valid_q && som_pkg::som_src_class(h_sel_q[0]) == som_pkg::SOM_SRC_ASRC);

    c_sin: cover property (@(posedge clk) disable iff (!rst_n)
        h_valid_q && som_pkg::som_src_class(h_sel_q[3]) == som_pkg::SOM_SRC_SIN);

    c_unmapped: cover property (@(posedge clk) disable iff (!rst_n)
        setup_ph && !(hit45 || hit67));

endmodule

`default_nettype wire

// *** hw/som_pkg.sv ***
// Constants, types and decode helpers for the serial output source selectors
// Assumes an APB register bus with 32-bit data and one 10 MHz clock
`default_nettype none

package som_pkg;

    // ************************************************************
    // Bus and register map
    // ************************************************************
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int REG_W = 8;
    localparam logic [ADDR_W-3:0] ROUTE45_IDX = 6'h15;
    localparam logic [ADDR_W-3:0] ROUTE67_IDX = 6'h16;
    localparam logic [REG_W-1:0] ROUTE45_RST = 8'h54;
    localparam logic [REG_W-1:0] ROUTE67_RST = 8'h76;

    // ************************************************************
    // Field layout
    // ************************************************************
    localparam int SEL_W = 4;
    localparam int SEL_LO_LSB = 0;
    localparam int SEL_HI_LSB = 4;

    // ************************************************************
    // Stream shape
    // ************************************************************
    localparam int SAMPLE_W = 24;
    localparam int ASRC_CH = 4;
    localparam int SIN_CH = 8;
    localparam int OUT_CH = 4;

    typedef enum logic [1:0] {
        SOM_SRC_RSVD = 2'b00,
        SOM_SRC_ASRC = 2'b01,
        SOM_SRC_SIN = 2'b10
    } som_src_t;

    // Top bit picks serial input, next bit the converter bank
    function automatic som_src_t som_src_class(input logic [SEL_W-1:0] sel);
        som_src_t c;
        c = SOM_SRC_RSVD;
        if (sel[3]) begin
            c = SOM_SRC_SIN;
        end else if (sel[2]) begin
            c = SOM_SRC_ASRC;
        end
        return c;
    endfunction

    // Byte address of a register index
    function automatic logic [ADDR_W-1:0] som_byte_addr(input logic [ADDR_W-3:0] idx);
        return {idx, 2'b00};
    endfunction

endpackage

`default_nettype wire

// *** hw/som_chan_mux.sv ***
// One serial output channel: picks its sample from the selected source
// Assumes sample inputs and the strobe come from logic on the same clock
`timescale 1ns/10ps
`default_nettype none

module som_chan_mux (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [som_pkg::SEL_W-1:0] sel,
    input wire logic [som_pkg::ASRC_CH-1:0][som_pkg::SAMPLE_W-1:0] asrc_sample,
    input wire logic [som_pkg::SIN_CH-1:0][som_pkg::SAMPLE_W-1:0] sin_sample,
    input wire logic sample_valid,
    output logic [som_pkg::SAMPLE_W-1:0] out_sample,
    output logic out_rsvd
);

    // ************************************************************
    // Source pick
    // ************************************************************
    // Reserved codes give silence rather than a stale or random word
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            out_sample <= '0;
        end else if (sample_valid) begin
            case (som_pkg::som_src_class(sel))
                som_pkg::SOM_SRC_ASRC: begin
                    out_sample <= asrc_sample[sel[1:0]];
                end
                som_pkg::SOM_SRC_SIN: begin
                    out_sample <= sin_sample[sel[2:0]];
                end
                default: begin
                    out_sample <= '0;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            out_rsvd <= 1'b0;
        end else begin
            out_rsvd <= (som_pkg::som_src_class(sel) == som_pkg::SOM_SRC_RSVD);
        end
    end

endmodule

`default_nettype wire

// *** bench/tb_som_route_top.sv ***
// Self-checking testbench for the channel 4 to 7 output source selectors
// Assumes som_pkg and the design files are compiled first; APB master on clk
`timescale 1ns/10ps
`default_nettype none

module tb_som_route_top;
    // ************************************************************
    // Signals and design
    // ************************************************************
    localparam logic [7:0] A45 = {som_pkg::ROUTE45_IDX, 2'b00};
    localparam logic [7:0] A67 = {som_pkg::ROUTE67_IDX, 2'b00};
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'hF;
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
    logic [som_pkg::ASRC_CH-1:0][som_pkg::SAMPLE_W-1:0] asrc_sample = '0;
    logic [som_pkg::SIN_CH-1:0][som_pkg::SAMPLE_W-1:0] sin_sample = '0;
    logic sample_valid = 1'b0;
    logic [som_pkg::OUT_CH-1:0][som_pkg::SAMPLE_W-1:0] out_sample;
    logic out_valid;
    logic [3:0] out_rsvd;
    logic [31:0] rd;
    logic err;
    int error_cnt = 0;
    int n_tests = 0;

    always #50 clk = ~clk;

    som_route_top u_som_route_top (.clk(clk), .rst_n(rst_n), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
        .pready(pready), .prdata(prdata), .pslverr(pslverr), .asrc_sample(asrc_sample),
        .sin_sample(sin_sample), .sample_valid(sample_valid), .out_sample(out_sample),
        .out_valid(out_valid), .out_rsvd(out_rsvd));

    // ************************************************************
    // Shared tasks
    // ************************************************************
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            $display("unexpected %s expected %h seen %h", what, exp, got);
            error_cnt++;
        end
    endtask

    // Waits on pready, never a fixed count; the watchdog ends a hang
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       input logic [3:0] s);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) begin
            @(posedge clk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic exp_err);
        apb(1'b0, a, 32'h0, 4'h0);
        chk("prdata", exp, rd);
        chk("pslverr", {31'h0, exp_err}, {31'h0, err});
    endtask

    // Sample words carry frame tag and source index so a wrong pick shows
    function automatic logic [23:0] exp_smp(input logic [3:0] code, input logic [7:0] tg);
        return code[3] ? {8'hB0, tg, 5'h00, code[2:0]} : {8'hA0, tg, 6'h00, code[1:0]};
    endfunction

    task automatic frame(input logic [7:0] tg);
        @(posedge clk);
        sample_valid <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            asrc_sample[i] <= {8'hA0, tg, 8'(i)};
        end
        for (int i = 0; i < 8; i++) begin
            sin_sample[i] <= {8'hB0, tg, 8'(i)};
        end
        @(posedge clk);
        sample_valid <= 1'b0;
    endtask

    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic t_reset();
        rd_chk(A45, 32'h0000_0054, 1'b0);
        rd_chk(A67, 32'h0000_0076, 1'b0);
        rd_chk(8'h5C, 32'h0, 1'b1);
        chk("out_rsvd", 32'h0, {28'h0, out_rsvd});
        chk("pready", 32'h1, {31'h0, pready});
        $display("test reset values done");
    endtask

    task automatic t_rw();
        apb(1'b1, A45, 32'hFFFF_FF9C, 4'hF);
        apb(1'b1, A67, 32'h0000_00E5, 4'h1);
        apb(1'b1, A45, 32'h0000_0077, 4'hE);
        apb(1'b1, 8'h50, 32'h0000_0011, 4'hF);
        chk("unmapped write err", 32'h1, {31'h0, err});
        rd_chk(A45, 32'h0000_009C, 1'b0);
        rd_chk(A67, 32'h0000_00E5, 1'b0);
        $display("test write readback done");
    endtask

    // Every legal code on every channel, channels offset so no two agree
    task automatic t_route();
        logic [3:0] sel [4];
        logic [7:0] tg;
        for (int c = 4; c < 16; c++) begin
            for (int k = 0; k < 4; k++) begin
                sel[k] = 4'(4 + (c - 4 + k) % 12);
            end
            tg = 8'(c);
            apb(1'b1, A45, {24'h0, sel[1], sel[0]}, 4'h1);
            apb(1'b1, A67, {24'h0, sel[3], sel[2]}, 4'h1);
            frame(tg);
            // Outputs looked at mid-cycle, once settled
            @(negedge clk);
            chk("out_valid", 32'h1, {31'h0, out_valid});
            for (int k = 0; k < 4; k++) begin
                chk("out_sample", {8'h0, exp_smp(sel[k], tg)}, {8'h0, out_sample[k]});
            end
            chk("out_rsvd", 32'h0, {28'h0, out_rsvd});
            @(negedge clk);
            chk("out_valid low", 32'h0, {31'h0, out_valid});
        end
        $display("test routing done");
    endtask

    task automatic t_rereset();
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        rd_chk(A45, 32'h0000_0054, 1'b0);
        rd_chk(A67, 32'h0000_0076, 1'b0);
        $display("test second reset done");
    endtask

    // ************************************************************
    // Sequence and verdict
    // ************************************************************
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_rw();
        t_route();
        t_rereset();
        conclude();
    end

    // Whole run is about 150 cycles; this leaves wide margin
    initial begin
        repeat (3000) @(posedge clk);
        error_cnt++;
        conclude();
    end
endmodule

`default_nettype wire
